/* File: common/cc_pkg.sv */
// shared constants, types and helpers for the capture/compare channel
package cc_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00; // channel_control
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h04; // result_low
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08; // result_high
  localparam logic [7:0] ADDR_STATUS = 8'h0C; // sticky events, read clears
  localparam logic [7:0] ADDR_MASK = 8'h10; // interrupt mask

  // ****************************************
  // reset values and field layout
  // ****************************************
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h3F; // bits 7-6 unimplemented
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [9:0] DUTY_RESET = 10'h000;
  localparam int STATUS_WIDTH = 2;
  localparam int ST_CHANNEL = 0; // channel_irq_flag
  localparam int ST_SPECIAL = 1; // special event trigger seen
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  // ****************************************
  // function_select codes
  // ****************************************
  localparam logic [3:0] FS_OFF = 4'h0;
  localparam logic [3:0] FS_CAP_FALL = 4'h4;
  localparam logic [3:0] FS_CAP_RISE = 4'h5;
  localparam logic [3:0] FS_CAP_4TH = 4'h6;
  localparam logic [3:0] FS_CAP_16TH = 4'h7;
  localparam logic [3:0] FS_CMP_SET = 4'h8;
  localparam logic [3:0] FS_CMP_CLR = 4'h9;
  localparam logic [3:0] FS_CMP_SWI = 4'hA;
  localparam logic [3:0] FS_CMP_SPECIAL = 4'hB;

  // ****************************************
  // prescaler counts (reset value and last count before a strobe)
  // ****************************************
  localparam logic [3:0] PRESCALE_RESET = 4'h0;
  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [1:0] unused; // reads zero
    logic duty_low_bit1;
    logic duty_low_bit0;
    logic [3:0] function_select;
  } control_t;

  typedef struct packed {
    logic [15:0] first_timer; // shared capture/compare time base
    logic [9:0] pwm_base; // second_timer with its 2 fine bits
    logic period_end; // pulse: second_timer reached its period
  } timebase_t;

  // ****************************************
  // mode decoding
  // ****************************************
  function automatic logic is_capture(input logic [3:0] fs);
    return fs[3:2] == 2'b01;
  endfunction

  function automatic logic is_compare(input logic [3:0] fs);
    return fs[3:2] == 2'b10;
  endfunction

  function automatic logic is_pwm(input logic [3:0] fs);
    return fs[3:2] == 2'b11;
  endfunction

endpackage

/* File: rtl/capture_qualifier.sv */
// pin synchroniser, edge detection and capture prescaler
`timescale 1ns/1ns
module capture_qualifier (
  // clock and reset
  input logic mclk,
  input logic reset,
  input logic ce,
  // pin and mode
  input logic channel_pin,
  input logic [3:0] function_select,
  // qualified event
  output logic capture_strobe
);

  // ****************************************
  // state
  // ****************************************
  logic sync1_r; // first synchroniser stage, read by sync2 only
  logic sync2_r;
  logic prev_r; // last synchronised level
  logic [3:0] count_r; // edge prescaler
  logic strobe_r;
  logic sync1_nxt, sync2_nxt, prev_nxt, strobe_nxt;
  logic [3:0] count_nxt;
  logic rise, fall;
  logic [3:0] last;

  // next-state logic
  always_comb begin
    sync1_nxt = channel_pin;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
    rise = sync2_r & ~prev_r;
    fall = ~sync2_r & prev_r;
    count_nxt = count_r;
    strobe_nxt = 1'b0;
    last = (function_select == cc_pkg::FS_CAP_4TH) ?
      cc_pkg::PRESCALE_4_LAST : cc_pkg::PRESCALE_16_LAST;
    case (function_select)
      cc_pkg::FS_CAP_FALL: begin
        strobe_nxt = fall;
      end
      cc_pkg::FS_CAP_RISE: begin
        strobe_nxt = rise;
      end
      cc_pkg::FS_CAP_4TH, cc_pkg::FS_CAP_16TH: begin
        // count not cleared on prescaler switch: may fire early
        if (rise) begin
          if (count_r >= last) begin
            count_nxt = cc_pkg::PRESCALE_RESET;
            strobe_nxt = 1'b1;
          end else begin
            count_nxt = count_r + 4'h1;
          end
        end
      end
      default: begin
        count_nxt = cc_pkg::PRESCALE_RESET;
      end
    endcase
  end

  // registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      count_r <= cc_pkg::PRESCALE_RESET;
      strobe_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
      count_r <= count_nxt;
      strobe_r <= strobe_nxt;
    end
  end

  assign capture_strobe = strobe_r;

  // ****************************************
  // checks
  // ****************************************
  property p_prescale_clear;
    @(posedge mclk) disable iff (reset)
    ce && !cc_pkg::is_capture(function_select) |=> count_r == 4'h0;
  endproperty
  a_prescale_clear: assert property (p_prescale_clear)
    else $error("prescaler not cleared outside capture");

  property p_single_strobe;
    @(posedge mclk) disable iff (reset)
    ce && strobe_r |=> !strobe_r;
  endproperty
  a_single_strobe: assert property (p_single_strobe)
    else $error("capture strobe longer than one cycle");

endmodule

/* File: rtl/capture_compare_control.sv */
// capture/compare/pwm channel with wishbone registers
// ****************************************
// ****************************************
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ns
module capture_compare_control (
  // clock, reset, enable
  input logic mclk,
  input logic reset,
  input logic ce,
  // wishbone classic slave
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [3:0] wb_sel_i,
  input logic [7:0] wb_adr_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // shared timers
  input cc_pkg::timebase_t timebase,
  input logic adc_enable,
  // channel pin
  input logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe,
  // system outputs
  output logic first_timer_reset,
  output logic adc_start,
  output logic irq
);

  // ****************************************
  // registers and next values
  // ****************************************
  cc_pkg::control_t control_r, control_nxt; // channel_control
  logic [15:0] result_r, result_nxt; // result_high:result_low
  logic [9:0] duty_latch_r, duty_latch_nxt; // pwm double buffer
  logic [1:0] status_r, status_nxt; // sticky events
  logic [1:0] mask_r, mask_nxt; // interrupt mask
  logic match_prev_r, match_prev_nxt; // last compare result
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic irq_r, irq_nxt;
  logic pin_out_r, pin_out_nxt; // compare/pwm output latch
  logic pin_oe_r, pin_oe_nxt;
  logic tmr_reset_r, tmr_reset_nxt;
  logic adc_start_r, adc_start_nxt;

  // ****************************************
  // decode
  // ****************************************
  logic req; // new request this cycle
  logic wr; // write to lane 0
  logic rd; // read
  logic [3:0] fs; // current function_select
  logic match; // first_timer equals result
  logic match_edge; // first cycle of a match
  logic cap_strobe; // qualified capture event
  logic [1:0] set_ev; // events this cycle
  logic [9:0] duty_new; // duty value from registers

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;
  assign fs = control_r.function_select;
  assign match = timebase.first_timer == result_r;
  assign match_edge = match & ~match_prev_r & cc_pkg::is_compare(fs);
  assign duty_new = {result_r[7:0], control_r.duty_low_bit1,
                     control_r.duty_low_bit0};

  // pin edges and prescaler; pin is sampled whatever its direction
  capture_qualifier u_qualifier (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .channel_pin(channel_pin_in),
    .function_select(fs),
    .capture_strobe(cap_strobe)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    control_nxt = control_r;
    result_nxt = result_r;
    duty_latch_nxt = duty_latch_r;
    mask_nxt = mask_r;
    pin_out_nxt = pin_out_r;
    match_prev_nxt = match;
    set_ev = 2'b00;
    tmr_reset_nxt = 1'b0;
    adc_start_nxt = 1'b0;
    ack_nxt = req;
    dat_nxt = 32'h0000_0000;

    // bus reads
    if (rd) begin
      case (wb_adr_i)
        cc_pkg::ADDR_CONTROL: begin
          dat_nxt[7:0] = control_r & cc_pkg::CONTROL_WMASK;
        end
        cc_pkg::ADDR_RESULT_LOW: begin
          dat_nxt[7:0] = result_r[7:0];
        end
        cc_pkg::ADDR_RESULT_HIGH: begin
          // pwm shows latched duty bits, else the stored value
          dat_nxt[7:0] = cc_pkg::is_pwm(fs) ? duty_latch_r[9:2] :
                         result_r[15:8];
        end
        cc_pkg::ADDR_STATUS: begin
          dat_nxt[1:0] = status_r;
        end
        cc_pkg::ADDR_MASK: begin
          dat_nxt[1:0] = mask_r;
        end
        default: begin
          dat_nxt = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end

    // compare actions
    if (match_edge) begin
      set_ev[cc_pkg::ST_CHANNEL] = 1'b1;
      case (fs)
        cc_pkg::FS_CMP_SET: begin
          pin_out_nxt = 1'b1;
        end
        cc_pkg::FS_CMP_CLR: begin
          pin_out_nxt = 1'b0;
        end
        cc_pkg::FS_CMP_SPECIAL: begin
          set_ev[cc_pkg::ST_SPECIAL] = 1'b1;
          tmr_reset_nxt = 1'b1;
          adc_start_nxt = adc_enable;
        end
        default: begin
          pin_out_nxt = pin_out_r;
        end
      endcase
    end

    // pwm: period start latches duty and sets pin unless duty is zero; match clears
    if (cc_pkg::is_pwm(fs)) begin
      if (timebase.period_end) begin
        duty_latch_nxt = duty_new;
        pin_out_nxt = duty_new != 10'h000;
      end else if (timebase.pwm_base == duty_latch_r) begin
        pin_out_nxt = 1'b0;
      end
    end

    // bus writes
    if (wr) begin
      case (wb_adr_i)
        cc_pkg::ADDR_CONTROL: begin
          control_nxt = wb_dat_i[7:0] & cc_pkg::CONTROL_WMASK;
          if (wb_dat_i[3:0] == cc_pkg::FS_OFF) begin
            pin_out_nxt = 1'b0;
            duty_latch_nxt = cc_pkg::DUTY_RESET;
          end
        end
        cc_pkg::ADDR_RESULT_LOW: begin
          result_nxt[7:0] = wb_dat_i[7:0];
        end
        cc_pkg::ADDR_RESULT_HIGH: begin
          if (!cc_pkg::is_pwm(fs)) begin
            result_nxt[15:8] = wb_dat_i[7:0];
          end
        end
        cc_pkg::ADDR_MASK: begin
          mask_nxt = wb_dat_i[1:0];
        end
        default: begin
          mask_nxt = mask_r; // unmapped writes ignored
        end
      endcase
    end

    // capture overwrites any older value, even unread
    if (cap_strobe && cc_pkg::is_capture(fs)) begin
      result_nxt = timebase.first_timer;
      set_ev[cc_pkg::ST_CHANNEL] = 1'b1;
    end

    // sticky status: read clears, a new event wins
    status_nxt = status_r;
    if (rd && wb_adr_i == cc_pkg::ADDR_STATUS) begin
      status_nxt = cc_pkg::STATUS_RESET;
    end
    status_nxt = status_nxt | set_ev;

    // pin drive only in set/clear compare and pwm
    pin_oe_nxt = (control_nxt.function_select == cc_pkg::FS_CMP_SET) ||
                 (control_nxt.function_select == cc_pkg::FS_CMP_CLR) ||
                 cc_pkg::is_pwm(control_nxt.function_select);
    irq_nxt = |(status_nxt & mask_nxt);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      control_r <= cc_pkg::CONTROL_RESET;
      result_r <= cc_pkg::RESULT_RESET;
      duty_latch_r <= cc_pkg::DUTY_RESET;
      status_r <= cc_pkg::STATUS_RESET;
      mask_r <= cc_pkg::MASK_RESET;
      match_prev_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      irq_r <= 1'b0;
      pin_out_r <= 1'b0;
      pin_oe_r <= 1'b0;
      tmr_reset_r <= 1'b0;
      adc_start_r <= 1'b0;
    end else if (ce) begin
      control_r <= control_nxt;
      result_r <= result_nxt;
      duty_latch_r <= duty_latch_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      match_prev_r <= match_prev_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      irq_r <= irq_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      tmr_reset_r <= tmr_reset_nxt;
      adc_start_r <= adc_start_nxt;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq = irq_r;
  assign channel_pin_out = pin_out_r;
  assign channel_pin_oe = pin_oe_r;
  assign first_timer_reset = tmr_reset_r;
  assign adc_start = adc_start_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic wr_ctrl;
  assign wr_ctrl = ce && wr && wb_adr_i == cc_pkg::ADDR_CONTROL;

  property p_off_resets;
    wr_ctrl && wb_dat_i[3:0] == 4'h0 |=>
      !pin_out_r && !pin_oe_r && duty_latch_r == 10'h000 &&
      control_r.function_select == 4'h0;
  endproperty
  a_off_resets: assert property (p_off_resets)
    else $error("off code did not reset the channel");

  property p_capture_copy;
    ce && cap_strobe && cc_pkg::is_capture(fs) |=>
      result_r == $past(timebase.first_timer);
  endproperty
  a_capture_copy: assert property (p_capture_copy)
    else $error("capture did not copy first_timer");

  property p_flag_sticky;
    status_r[0] && !(ce && rd && wb_adr_i == cc_pkg::ADDR_STATUS)
      |=> status_r[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("channel flag cleared itself");

  property p_overwrite;
    ce && cap_strobe && cc_pkg::is_capture(fs) && status_r[0] |=>
      status_r[0] && result_r == $past(timebase.first_timer);
  endproperty
  a_overwrite: assert property (p_overwrite)
    else $error("unread result not overwritten");

  property p_cmp_set;
    ce && match_edge && fs == cc_pkg::FS_CMP_SET && !wr_ctrl |=>
      pin_out_r && pin_oe_r && status_r[0];
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("set-on-match failed");

  property p_cmp_clr;
    ce && match_edge && fs == cc_pkg::FS_CMP_CLR && !wr_ctrl |=>
      !pin_out_r && status_r[0];
  endproperty
  a_cmp_clr: assert property (p_cmp_clr)
    else $error("clear-on-match failed");

  property p_swi_pin;
    fs == cc_pkg::FS_CMP_SWI || fs == cc_pkg::FS_CMP_SPECIAL |->
      !pin_oe_r;
  endproperty
  a_swi_pin: assert property (p_swi_pin)
    else $error("pin driven in interrupt-only compare");

  property p_special;
    ce && match_edge && fs == cc_pkg::FS_CMP_SPECIAL |=>
      first_timer_reset && adc_start == $past(adc_enable) ##1
      !first_timer_reset;
  endproperty
  a_special: assert property (p_special)
    else $error("special event outputs wrong");

  property p_pwm_latch;
    ce && cc_pkg::is_pwm(fs) && timebase.period_end && !wr |=>
      duty_latch_r == $past(duty_new) && pin_out_r == ($past(duty_new) != 0);
  endproperty
  a_pwm_latch: assert property (p_pwm_latch)
    else $error("pwm duty not latched at period end");

  property p_reserved_zero;
    ce && rd && wb_adr_i == cc_pkg::ADDR_CONTROL |=>
      wb_ack_o && wb_dat_o[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unimplemented control bits read nonzero");

  c_capture: cover property (ce && cap_strobe && cc_pkg::is_capture(fs));
  c_cmp_match: cover property (ce && match_edge && pin_oe_r);
  c_pwm_period: cover property (cc_pkg::is_pwm(fs) && timebase.period_end);
  c_irq: cover property (irq ##1 !irq);

endmodule

/* File: verif/pin_partner.sv */
// far-side model: outside pin source and load, plus the shared time bases
`timescale 1ns/1ns
module pin_partner #(
  parameter logic [9:0] PERIOD_LAST = 10'h03F // last count of second_timer
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // level the outside world puts on the pin while the channel lets go
  input wire logic drive_level,
  // channel side
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic first_timer_reset,
  output logic channel_pin,
  output cc_pkg::timebase_t timebase
);
  // ****************************************
  // time bases
  // ****************************************
  logic [15:0] ft_r; // first_timer count
  logic [15:0] ft_nxt;
  logic [9:0] pb_r; // second_timer with fine bits
  logic [9:0] pb_nxt;

  // a driven pin feeds straight back into the capture input
  assign channel_pin = pin_oe ? pin_out : drive_level;

  // timer steps on the system clock, so capture stays synchronous
  always_comb begin
    ft_nxt = first_timer_reset ? 16'h0000 : ft_r + 16'h0001;
    pb_nxt = (pb_r == PERIOD_LAST) ? 10'h000 : pb_r + 10'h001;
  end

  // registers only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ft_r <= 16'h0000;
      pb_r <= 10'h000;
    end else begin
      ft_r <= ft_nxt;
      pb_r <= pb_nxt;
    end
  end

  // period end pulses in the last count of the period
  assign timebase = {ft_r, pb_r, pb_r == PERIOD_LAST};
endmodule

/* File: verif/capture_compare_control_tb.sv */
// self-checking testbench for the capture/compare channel
`timescale 1ns/1ns
module capture_compare_control_tb;
  // ****************************************
  // signals
  // ****************************************
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000;
  logic [31:0] rdat;
  logic ack, pin_in, pin_out, pin_oe, ftr, adc_go, irq;
  logic ext_level = 1'b0; // outside pin level
  logic adc_en = 1'b1;
  cc_pkg::timebase_t tb_time;
  logic ftr_seen = 1'b0; // timer reset pulse seen
  logic adc_seen = 1'b0; // conversion start seen
  logic [15:0] stamp; // first_timer when the pin last moved
  int error_cnt = 0;
  int n_tests = 0;

  // 250 MHz clock
  always #2 mclk = ~mclk;

  pin_partner far (.mclk(mclk), .reset(reset), .drive_level(ext_level),
    .pin_out(pin_out), .pin_oe(pin_oe), .first_timer_reset(ftr),
    .channel_pin(pin_in), .timebase(tb_time));

  capture_compare_control dut (.mclk(mclk), .reset(reset), .ce(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timebase(tb_time), .adc_enable(adc_en), .channel_pin_in(pin_in),
    .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
    .first_timer_reset(ftr), .adc_start(adc_go), .irq(irq));

  // remember one-cycle pulses for later comparison
  always @(posedge mclk) begin
    if (ftr) ftr_seen <= 1'b1;
    if (adc_go) adc_seen <= 1'b1;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 40) chk("ack", 16'h0001, 16'h0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask

  // move the pin and give the synchroniser time to settle
  task automatic edge_to(input logic lvl);
    @(posedge mclk);
    ext_level <= lvl;
    stamp = tb_time.first_timer;
    repeat (6) @(posedge mclk);
  endtask

  task automatic pulse();
    edge_to(1'b1);
    edge_to(1'b0);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    chk("irq_wait", 16'h0000, {15'h0000, n >= 300});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    rd_chk("control", cc_pkg::ADDR_CONTROL, 8'h00);
    rd_chk("result_low", cc_pkg::ADDR_RESULT_LOW, 8'h00);
    rd_chk("result_high", cc_pkg::ADDR_RESULT_HIGH, 8'h00);
    rd_chk("status", cc_pkg::ADDR_STATUS, 8'h00);
    rd_chk("mask", cc_pkg::ADDR_MASK, 8'h00);
    rd_chk("unmapped", 8'h14, 8'h00);
    wr(cc_pkg::ADDR_CONTROL, 8'hFF);
    rd_chk("control_top", cc_pkg::ADDR_CONTROL, 8'h3F);
    wr(cc_pkg::ADDR_CONTROL, 8'h00);
  endtask

  // every capture mode, its edge count, overwrite and sticky flag
  task automatic t_capture();
    logic [3:0] md [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int cnt [4] = '{1, 2, 4, 16};
    logic [7:0] lo, hi;
    logic [15:0] d;
    wr(cc_pkg::ADDR_MASK, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(cc_pkg::ADDR_CONTROL, 8'h00);
      wr(cc_pkg::ADDR_CONTROL, {4'h0, md[m]});
      bus(1'b0, cc_pkg::ADDR_STATUS, 8'h00, lo);
      for (int i = 0; i < cnt[m] - 1; i++) pulse();
      rd_chk("st_early", cc_pkg::ADDR_STATUS, {7'h00, md[m] == 4'h5});
      // every mode sees a rise first; fall mode must ignore it
      edge_to(1'b1);
      if (md[m] == 4'h4) begin
        rd_chk("st_rise", cc_pkg::ADDR_STATUS, 8'h00);
        edge_to(1'b0);
      end
      chk("irq_on", 16'h0001, {15'h0000, irq});
      rd_chk("st_set", cc_pkg::ADDR_STATUS, 8'h01);
      rd_chk("st_clr", cc_pkg::ADDR_STATUS, 8'h00);
      bus(1'b0, cc_pkg::ADDR_RESULT_LOW, 8'h00, lo);
      bus(1'b0, cc_pkg::ADDR_RESULT_HIGH, 8'h00, hi);
      d = {hi, lo} - stamp;
      chk("cap_time", 16'h0001, {15'h0000, d >= 2 && d <= 7});
      if (ext_level) edge_to(1'b0);
    end
  endtask

  // direct prescaler change keeps the count; turning off clears it
  task automatic t_prescale();
    logic [7:0] q;
    wr(cc_pkg::ADDR_MASK, 8'h00);
    wr(cc_pkg::ADDR_CONTROL, 8'h07);
    repeat (5) pulse();
    wr(cc_pkg::ADDR_CONTROL, 8'h06);
    bus(1'b0, cc_pkg::ADDR_STATUS, 8'h00, q);
    pulse();
    chk("irq_masked", 16'h0000, {15'h0000, irq});
    rd_chk("st_spurious", cc_pkg::ADDR_STATUS, 8'h01);
    // leave a count of two behind, so only the off write can clear it
    repeat (2) pulse();
    wr(cc_pkg::ADDR_CONTROL, 8'h00);
    wr(cc_pkg::ADDR_CONTROL, 8'h06);
    bus(1'b0, cc_pkg::ADDR_STATUS, 8'h00, q);
    repeat (3) pulse();
    rd_chk("st_cleared", cc_pkg::ADDR_STATUS, 8'h00);
    wr(cc_pkg::ADDR_CONTROL, 8'h00);
  endtask

  // compare codes in turn, switched without passing through off;
  // the last special event runs with the converter disabled
  task automatic t_compare();
    logic [3:0] md [6] = '{4'h8, 4'hA, 4'h9, 4'h8, 4'hB, 4'hB};
    logic ep [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [15:0] tgt;
    logic sp;
    wr(cc_pkg::ADDR_MASK, 8'h03);
    for (int i = 0; i < 6; i++) begin
      adc_en <= (i != 5);
      sp = (md[i] == 4'hB);
      tgt = tb_time.first_timer + 16'h0040;
      wr(cc_pkg::ADDR_RESULT_LOW, tgt[7:0]);
      wr(cc_pkg::ADDR_RESULT_HIGH, tgt[15:8]);
      ftr_seen <= 1'b0;
      adc_seen <= 1'b0;
      wr(cc_pkg::ADDR_CONTROL, {4'h0, md[i]});
      wait_irq();
      repeat (2) @(posedge mclk);
      chk("cmp_pin", {15'h0000, ep[i]}, {15'h0000, pin_out});
      if (!md[i][1]) chk("cmp_oe", 16'h0001, {15'h0000, pin_oe});
      chk("tmr_reset", {15'h0000, sp}, {15'h0000, ftr_seen});
      chk("adc_go", {15'h0000, sp && i != 5}, {15'h0000, adc_seen});
      rd_chk("cmp_st", cc_pkg::ADDR_STATUS, {6'h00, sp, 1'b1});
    end
    wr(cc_pkg::ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge mclk);
    chk("off_pin", 16'h0000, {15'h0000, pin_out});
    chk("off_oe", 16'h0000, {15'h0000, pin_oe});
  endtask

  // duty {0x05, 0, 1} = 21 counts of the second_timer
  task automatic t_pwm();
    int n;
    int hi;
    wr(cc_pkg::ADDR_RESULT_LOW, 8'h05);
    wr(cc_pkg::ADDR_CONTROL, 8'h1C);
    n = 0;
    while (pin_out !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    while (pin_out !== 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    hi = 0;
    while (pin_out === 1'b1 && hi < 200) begin
      @(posedge mclk);
      hi++;
    end
    chk("pwm_width", 16'h0001, {15'h0000, hi >= 20 && hi <= 23});
    chk("pwm_oe", 16'h0001, {15'h0000, pin_oe});
    rd_chk("duty_high", cc_pkg::ADDR_RESULT_HIGH, 8'h05);
    wr(cc_pkg::ADDR_CONTROL, 8'h00);
  endtask

  // ****************************************
  // verdict
  // ****************************************
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_capture();
    t_prescale();
    t_compare();
    t_pwm();
    summarize();
  end

  // watchdog: far beyond the thousand-odd cycles the tests need
  initial begin
    #80000;
    error_cnt++;
    summarize();
  end
endmodule
